/* File: hdl/ctlo_pkg.sv */
// Functional notes
// R01 - Bit 7 of the clock-prepare register picks the automatic interval at 0 and bits 6:0 at 1.
// R02 - Bit 7 of the clock-zero register picks the automatic interval at 0 and bits 6:0 at 1.
// R03 - Bit 7 of the clock-trail register picks the automatic interval at 0 and bits 6:0 at 1.
// R04 - Bit 7 of the clock-post register picks the automatic interval at 0 and bits 6:0 at 1.
// R05 - With override at 0 the value field reads the automatic interval and ignores writes.
// R06 - With override at 1 the value field is read/write and its stored value is used.
// R07 - Automatic intervals follow the selected lane rate, defaulting to the 800 Mbps figures.
// R08 - Clock-prepare register sits at index 0x40 and resets to 0x05.
// R09 - Clock-zero register sits at index 0x41 and resets to 0x1B.
// R10 - Clock-trail register sits at index 0x42 and resets to 0x0B.
// R11 - Clock-post register sits at index 0x43 and resets to 0x0A.
// R12 - Lane rate is an input, auto values come from a table, chosen ones time the clock lane.
package ctlo_pkg;

   localparam int ADDR_W = 12;

   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_PREP  = 10'h040;
   localparam logic [9:0] IDX_ZERO  = 10'h041;
   localparam logic [9:0] IDX_TRAIL = 10'h042;
   localparam logic [9:0] IDX_POST  = 10'h043;

   localparam int OV_BIT  = 7;
   localparam int VAL_MSB = 6;

   localparam logic [7:0] RST_PREP  = 8'h05;
   localparam logic [7:0] RST_ZERO  = 8'h1B;
   localparam logic [7:0] RST_TRAIL = 8'h0B;
   localparam logic [7:0] RST_POST  = 8'h0A;

   // lane rate codes on lane_rate_sel
   localparam logic [2:0] RATE_400  = 3'h0;
   localparam logic [2:0] RATE_800  = 3'h1;
   localparam logic [2:0] RATE_1200 = 3'h2;
   localparam logic [2:0] RATE_1500 = 3'h3;
   localparam logic [2:0] RATE_1600 = 3'h4;

   // auto intervals in aclk cycles, per rate: {post, trail, zero, prep}
   localparam logic [4:0][3:0][6:0] AUTO_TBL = '{
      '{7'h10, 7'h15, 7'h36, 7'h09},
      '{7'h0F, 7'h14, 7'h32, 7'h09},
      '{7'h0D, 7'h10, 7'h28, 7'h07},
      '{RST_POST[6:0], RST_TRAIL[6:0], RST_ZERO[6:0], RST_PREP[6:0]},
      '{7'h07, 7'h06, 7'h0E, 7'h03}};

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [2:0] {LN_LP, LN_PREP, LN_ZERO, LN_HS, LN_POST, LN_TRAIL} ctlo_lane_t;

   typedef struct packed {
      logic                awready;
      logic                wready;
      logic                aw_full;
      logic                w_full;
      logic [ADDR_W-1:0]   aw_addr;
      logic [7:0]          w_byte;
      logic                w_lane0;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
      logic [3:0]          ov;
      logic [3:0][6:0]     val;
      ctlo_lane_t          lane;
      logic [6:0]          cnt;
      logic                lp_drive;
      logic                hs_drive;
      logic                hs_toggle;
      logic                hs_ready;
   } ctlo_state_t;

endpackage

/* File: hdl/ctlo_regs.sv */
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ctlo_regs
(
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [ctlo_pkg::ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output      logic                          s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output      logic                          s_axi_wready,
   output      logic [1:0]                    s_axi_bresp,
   output      logic                          s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [ctlo_pkg::ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output      logic                          s_axi_arready,
   output      logic [31:0]                   s_axi_rdata,
   output      logic [1:0]                    s_axi_rresp,
   output      logic                          s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic [2:0]                    lane_rate_sel,
   input  wire logic                          hs_clk_req,
   output      logic                          clk_lp_drive,
   output      logic                          clk_hs_drive,
   output      logic                          clk_hs_toggle,
   output      logic                          clk_hs_ready
);

   ctlo_pkg::ctlo_state_t st;
   ctlo_pkg::ctlo_state_t next_st;
   logic [3:0][6:0]       auto_v;
   logic [3:0][6:0]       eff;

   // returns {hit, register slot}; slot 0..3 = prep, zero, trail, post
   function automatic logic [2:0] reg_sel(input logic [ctlo_pkg::ADDR_W-1:0] a);
      logic [9:0] idx;
      idx = a[ctlo_pkg::ADDR_W-1:2];
      unique case (idx)
         ctlo_pkg::IDX_PREP:  reg_sel = 3'h4;
         ctlo_pkg::IDX_ZERO:  reg_sel = 3'h5;
         ctlo_pkg::IDX_TRAIL: reg_sel = 3'h6;
         ctlo_pkg::IDX_POST:  reg_sel = 3'h7;
         default:             reg_sel = 3'h0;
      endcase
   endfunction

   // a zero interval would wrap the counter to 127 and run 128 cycles, so it is stretched to one cycle
   function automatic logic [6:0] at_least_one(input logic [6:0] v);
      at_least_one = (v == 7'h00) ? 7'h01 : v;
   endfunction

   always_comb
   begin
      // unknown rate codes fall back to the 800 Mbps set
      unique case (lane_rate_sel)
         ctlo_pkg::RATE_400:  auto_v = ctlo_pkg::AUTO_TBL[0]; // R07
         ctlo_pkg::RATE_1200: auto_v = ctlo_pkg::AUTO_TBL[2]; // R07
         ctlo_pkg::RATE_1500: auto_v = ctlo_pkg::AUTO_TBL[3]; // R07
         ctlo_pkg::RATE_1600: auto_v = ctlo_pkg::AUTO_TBL[4]; // R07
         default:             auto_v = ctlo_pkg::AUTO_TBL[1]; // R07
      endcase
      for (int i = 0; i < 4; i++)
      begin
         eff[i] = at_least_one(st.ov[i] ? st.val[i] : auto_v[i]); // R01 R02 R03 R04 R12
      end
   end

   always_comb
   begin
      logic [2:0] ws;
      logic [2:0] rs;
      next_st = st;
      ws = reg_sel(st.aw_addr);
      rs = reg_sel(s_axi_araddr);

      // write address and data are caught separately, in either order
      if (s_axi_awvalid && st.awready)
      begin
         next_st.aw_addr = s_axi_awaddr;
         next_st.aw_full = 1'b1;
         next_st.awready = 1'b0;
      end
      if (s_axi_wvalid && st.wready)
      begin
         next_st.w_byte  = s_axi_wdata[7:0];
         next_st.w_lane0 = s_axi_wstrb[0];
         next_st.w_full  = 1'b1;
         next_st.wready  = 1'b0;
      end
      if (st.aw_full && st.w_full && !st.bvalid)
      begin
         next_st.bvalid = 1'b1;
         next_st.bresp  = ws[2] ? ctlo_pkg::RESP_OKAY : ctlo_pkg::RESP_DECERR;
         if (ws[2] && st.w_lane0)
         begin
            next_st.ov[ws[1:0]] = st.w_byte[ctlo_pkg::OV_BIT];
            if (st.ov[ws[1:0]])
            begin
               next_st.val[ws[1:0]] = st.w_byte[ctlo_pkg::VAL_MSB:0]; // R06
            end
            else
            begin
               // field is read-only here; on override entry it keeps the live auto value
               next_st.val[ws[1:0]] = auto_v[ws[1:0]]; // R05
            end
         end
      end
      if (st.bvalid && s_axi_bready)
      begin
         next_st.bvalid  = 1'b0;
         next_st.aw_full = 1'b0;
         next_st.w_full  = 1'b0;
         next_st.awready = 1'b1;
         next_st.wready  = 1'b1;
      end

      if (s_axi_arvalid && st.arready)
      begin
         next_st.arready = 1'b0;
         next_st.rvalid  = 1'b1;
         next_st.rresp   = rs[2] ? ctlo_pkg::RESP_OKAY : ctlo_pkg::RESP_DECERR;
         next_st.rdata   = 32'h0000_0000;
         if (rs[2])
         begin
            next_st.rdata[ctlo_pkg::OV_BIT] = st.ov[rs[1:0]];
            next_st.rdata[ctlo_pkg::VAL_MSB:0] =
               st.ov[rs[1:0]] ? st.val[rs[1:0]] : auto_v[rs[1:0]]; // R05 R06
         end
      end
      if (st.rvalid && s_axi_rready)
      begin
         next_st.rvalid  = 1'b0;
         next_st.arready = 1'b1;
      end

      // clock-lane sequence: LP -> prepare -> zero -> HS clock -> post -> trail -> LP
      next_st.cnt = st.cnt - 7'h01;
      unique case (st.lane)
         ctlo_pkg::LN_LP:
         begin
            next_st.cnt = st.cnt;
            if (hs_clk_req)
            begin
               next_st.lane = ctlo_pkg::LN_PREP;
               next_st.cnt  = eff[0]; // R01
            end
         end
         ctlo_pkg::LN_PREP:
         begin
            if (st.cnt == 7'h01)
            begin
               next_st.lane = ctlo_pkg::LN_ZERO;
               next_st.cnt  = eff[1]; // R02
            end
         end
         ctlo_pkg::LN_ZERO:
         begin
            if (st.cnt == 7'h01)
            begin
               next_st.lane = ctlo_pkg::LN_HS;
            end
         end
         ctlo_pkg::LN_HS:
         begin
            next_st.cnt = st.cnt;
            // the clock keeps running through post so the receiver sees the last data
            if (!hs_clk_req)
            begin
               next_st.lane = ctlo_pkg::LN_POST;
               next_st.cnt  = eff[3]; // R04
            end
         end
         ctlo_pkg::LN_POST:
         begin
            if (st.cnt == 7'h01)
            begin
               next_st.lane = ctlo_pkg::LN_TRAIL;
               next_st.cnt  = eff[2]; // R03
            end
         end
         ctlo_pkg::LN_TRAIL:
         begin
            if (st.cnt == 7'h01)
            begin
               next_st.lane = ctlo_pkg::LN_LP;
            end
         end
         default:
         begin
            next_st.lane = ctlo_pkg::LN_LP;
         end
      endcase
      next_st.lp_drive  = next_st.lane inside {ctlo_pkg::LN_LP, ctlo_pkg::LN_PREP}; // R12
      next_st.hs_drive  = !next_st.lp_drive;
      next_st.hs_toggle = next_st.lane inside {ctlo_pkg::LN_HS, ctlo_pkg::LN_POST};
      next_st.hs_ready  = next_st.lane == ctlo_pkg::LN_HS;

      if (!aresetn)
      begin
         next_st         = '0;
         next_st.awready = 1'b1;
         next_st.wready  = 1'b1;
         next_st.arready = 1'b1;
         next_st.lane    = ctlo_pkg::LN_LP;
         next_st.cnt     = 7'h01;
         next_st.lp_drive = 1'b1;
         next_st.ov      = 4'h0;
         next_st.val[0]  = ctlo_pkg::RST_PREP[6:0];  // R08
         next_st.val[1]  = ctlo_pkg::RST_ZERO[6:0];  // R09
         next_st.val[2]  = ctlo_pkg::RST_TRAIL[6:0]; // R10
         next_st.val[3]  = ctlo_pkg::RST_POST[6:0];  // R11
      end
   end

   always_ff @(posedge aclk)
   begin
      st <= next_st;
   end

   assign s_axi_awready = st.awready;
   assign s_axi_wready  = st.wready;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;
   assign clk_lp_drive  = st.lp_drive;
   assign clk_hs_drive  = st.hs_drive;
   assign clk_hs_toggle = st.hs_toggle;
   assign clk_hs_ready  = st.hs_ready;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_prep_len: assert property ( // R01
      $past(st.lane) == ctlo_pkg::LN_LP && st.lane == ctlo_pkg::LN_PREP |->
      st.cnt == at_least_one($past(st.ov[0]) ? $past(st.val[0]) : $past(auto_v[0])))
      else $error("prepare interval not taken from selected source");

   a_zero_len: assert property ( // R02
      $past(st.lane) == ctlo_pkg::LN_PREP && st.lane == ctlo_pkg::LN_ZERO |->
      st.cnt == at_least_one($past(st.ov[1]) ? $past(st.val[1]) : $past(auto_v[1])))
      else $error("zero interval not taken from selected source");

   a_trail_len: assert property ( // R03
      $past(st.lane) == ctlo_pkg::LN_POST && st.lane == ctlo_pkg::LN_TRAIL |->
      st.cnt == at_least_one($past(st.ov[2]) ? $past(st.val[2]) : $past(auto_v[2])))
      else $error("trail interval not taken from selected source");

   a_post_len: assert property ( // R04
      $past(st.lane) == ctlo_pkg::LN_HS && st.lane == ctlo_pkg::LN_POST |->
      st.cnt == at_least_one($past(st.ov[3]) ? $past(st.val[3]) : $past(auto_v[3])))
      else $error("post interval not taken from selected source");

   a_auto_read: assert property ( // R05
      s_axi_arvalid && st.arready && reg_sel(s_axi_araddr) == 3'h4 && !st.ov[0] |=>
      st.rvalid && st.rdata[7:0] == {1'b0, $past(auto_v[0])})
      else $error("auto prepare value not returned on read");

   a_ovr_write: assert property ( // R06
      st.aw_full && st.w_full && !st.bvalid && reg_sel(st.aw_addr) == 3'h5 &&
      st.w_lane0 && st.ov[1] |=> st.val[1] == $past(st.w_byte[6:0]) ##1 $stable(st.val[1]))
      else $error("overridden zero value not stored");

   a_rate_dflt: assert property ( // R07
      lane_rate_sel == ctlo_pkg::RATE_800 |->
      auto_v[0] == 7'h05 && auto_v[1] == 7'h1B && auto_v[2] == 7'h0B && auto_v[3] == 7'h0A)
      else $error("800 Mbps auto set wrong");

   a_reset_vals: assert property ( // R08
      $rose(aresetn) |-> st.ov == 4'h0 && st.val[0] == 7'h05 && st.val[1] == 7'h1B &&
      st.val[2] == 7'h0B && st.val[3] == 7'h0A)
      else $error("timing registers not at reset values");

   a_hs_window: assert property ( // R12
      $rose(st.hs_ready) |-> $past(st.lane) == ctlo_pkg::LN_ZERO ##1 st.hs_toggle)
      else $error("hs clock ready without zero phase");

   // map checks spell out byte addresses so they do not lean on the decoder function
   a_wr_decode: assert property ( // R08 R09 R10 R11
      st.aw_full && st.w_full && !st.bvalid |=>
      st.bvalid && st.bresp == (($past(st.aw_addr[11:4]) == 8'h10) ? 2'h0 : 2'h3))
      else $error("write response does not match the register map");

   a_rd_decode: assert property ( // R08 R09 R10 R11
      s_axi_arvalid && st.arready && s_axi_araddr[11:4] != 8'h10 |=>
      st.rvalid && st.rresp == 2'h3 && st.rdata == 32'h0000_0000)
      else $error("unmapped read not refused");

   a_ov_readback: assert property ( // R01
      s_axi_arvalid && st.arready && s_axi_araddr == 12'h100 |=>
      st.rdata[7] == $past(st.ov[0]))
      else $error("prepare override bit not returned on read");

   a_ov_store: assert property ( // R02
      st.aw_full && st.w_full && !st.bvalid && st.aw_addr == 12'h104 && st.w_lane0 |=>
      st.ov[1] == $past(st.w_byte[7]))
      else $error("zero override bit not stored");

   a_ro_field: assert property ( // R05
      st.aw_full && st.w_full && !st.bvalid && st.aw_addr == 12'h108 && st.w_lane0 &&
      !st.ov[2] |=> st.val[2] == $past(auto_v[2]))
      else $error("read-only trail field took the written value");

   a_ovr_read: assert property ( // R06
      s_axi_arvalid && st.arready && s_axi_araddr == 12'h10C && st.ov[3] |=>
      st.rvalid && st.rdata[7:0] == {1'b1, $past(st.val[3])})
      else $error("overridden post value not returned on read");

   a_strb_drop: assert property ( // R06
      st.aw_full && st.w_full && !st.bvalid && !st.w_lane0 |=>
      $stable(st.ov) && $stable(st.val))
      else $error("write without byte lane 0 changed a register");

   a_rate_slow: assert property ( // R07
      lane_rate_sel == ctlo_pkg::RATE_400 |->
      auto_v[0] == 7'h03 && auto_v[1] == 7'h0E && auto_v[2] == 7'h06 && auto_v[3] == 7'h07)
      else $error("400 Mbps auto set wrong");

   a_lane_idle: assert property ( // R12
      st.lane == ctlo_pkg::LN_LP && !hs_clk_req |=>
      st.lane == ctlo_pkg::LN_LP && st.lp_drive)
      else $error("clock lane left low power without a request");

   a_hs_hold: assert property ( // R12
      st.lane == ctlo_pkg::LN_HS && hs_clk_req |=>
      st.hs_ready && st.hs_toggle)
      else $error("hs clock dropped while still requested");

   a_post_phase: assert property ( // R12
      st.lane == ctlo_pkg::LN_POST |->
      st.hs_toggle && !st.hs_ready && st.hs_drive)
      else $error("post phase outputs wrong");

   a_drive_excl: assert property ( // R12
      st.hs_drive != st.lp_drive)
      else $error("lp and hs drivers not exclusive");

   c_override: cover property (st.bvalid && st.bresp == ctlo_pkg::RESP_OKAY && |st.ov);
   c_auto_read: cover property (st.rvalid && st.rresp == ctlo_pkg::RESP_OKAY && !st.ov[0]);
   c_lane_cycle: cover property (st.lane == ctlo_pkg::LN_TRAIL ##1 st.lane == ctlo_pkg::LN_LP);
   c_decerr: cover property (st.rvalid && st.rresp == ctlo_pkg::RESP_DECERR);
   c_wr_decerr: cover property (st.bvalid && st.bresp == ctlo_pkg::RESP_DECERR);

endmodule

/* File: tb/csi2_clock_lane_timing_override_tb.sv */
`timescale 1ns/100ps
module csi2_clock_lane_timing_override_tb;
   logic                        aclk;
   logic                        aresetn;
   logic [ctlo_pkg::ADDR_W-1:0] s_axi_awaddr;
   logic                        s_axi_awvalid;
   logic                        s_axi_awready;
   logic [31:0]                 s_axi_wdata;
   logic [3:0]                  s_axi_wstrb;
   logic                        s_axi_wvalid;
   logic                        s_axi_wready;
   logic [1:0]                  s_axi_bresp;
   logic                        s_axi_bvalid;
   logic                        s_axi_bready;
   logic [ctlo_pkg::ADDR_W-1:0] s_axi_araddr;
   logic                        s_axi_arvalid;
   logic                        s_axi_arready;
   logic [31:0]                 s_axi_rdata;
   logic [1:0]                  s_axi_rresp;
   logic                        s_axi_rvalid;
   logic                        s_axi_rready;
   logic [2:0]                  lane_rate_sel;
   logic                        hs_clk_req;
   logic                        clk_lp_drive;
   logic                        clk_hs_drive;
   logic                        clk_hs_toggle;
   logic                        clk_hs_ready;
   int                          err_total;
   int                          n_tests;
   // expected auto intervals per rate code: prep, zero, trail, post; code 5 behaves as 800
   logic [6:0]                  auto_v [6][4] = '{'{7'h03, 7'h0E, 7'h06, 7'h07},
      '{7'h05, 7'h1B, 7'h0B, 7'h0A}, '{7'h07, 7'h28, 7'h10, 7'h0D},
      '{7'h09, 7'h32, 7'h14, 7'h0F}, '{7'h09, 7'h36, 7'h15, 7'h10},
      '{7'h05, 7'h1B, 7'h0B, 7'h0A}};
   // override intervals kept short so the lane walk stays quick
   logic [6:0]                  ovr_v [4] = '{7'h02, 7'h04, 7'h05, 7'h03};
   logic [31:0]                 rst_v [4] = '{32'h0000_0005, 32'h0000_001B, 32'h0000_000B,
      32'h0000_000A};
   logic [1:0]                  ok;
   logic [1:0]                  dec;
   int                          n;

   ctlo_regs ctlo_regs_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lane_rate_sel, .hs_clk_req,
      .clk_lp_drive, .clk_hs_drive, .clk_hs_toggle, .clk_hs_ready);

   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic final_report();
      if (err_total == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_cycles(input string what, input int exp, input int got);
      n_tests++;
      if (got != exp)
      begin
         err_total++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // address and data are offered together; each is released at the edge that takes it
   task automatic axi_write(input logic [9:0] idx, input logic [7:0] d, input logic strb,
                            input logic [1:0] exp_resp);
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= {24'h00_0000, d};
      s_axi_wstrb   <= {3'b000, strb};
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      cmp_resp("write response", exp_resp, s_axi_bresp);
      // one spare edge so a following call does not reassign bready in this step
      @(posedge aclk);
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp,
                         input logic [1:0] exp_resp);
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      cmp_word("read data", exp, s_axi_rdata);
      cmp_resp("read response", exp_resp, s_axi_rresp);
      @(posedge aclk);
   endtask

   // counts edges until the chosen lane output is sampled at the wanted level
   task automatic wait_lane(input int sel, input logic lvl, output int cnt);
      logic [3:0] mon;
      cnt = 0;
      do
      begin
         @(posedge aclk);
         cnt++;
         mon = {clk_lp_drive, clk_hs_toggle, clk_hs_ready, clk_hs_drive};
      end
      while (mon[sel] !== lvl && cnt < 300);
   endtask

   task automatic lane_run(input int p, input int z, input int tp, input int tt);
      hs_clk_req <= 1'b1;
      wait_lane(0, 1'b1, n);
      cmp_cycles("prepare", p + 2, n);
      wait_lane(1, 1'b1, n);
      cmp_cycles("zero", z, n);
      hs_clk_req <= 1'b0;
      wait_lane(2, 1'b0, n);
      cmp_cycles("post", tp + 2, n);
      wait_lane(3, 1'b1, n);
      cmp_cycles("trail", tt, n);
   endtask

   initial
   begin
      repeat (20000) @(posedge aclk);
      err_total++;
      final_report();
   end

   initial
   begin
      ok = ctlo_pkg::RESP_OKAY;
      dec = ctlo_pkg::RESP_DECERR;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, hs_clk_req} = '0;
      lane_rate_sel = ctlo_pkg::RATE_800;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int j = 0; j < 4; j++)
         rd_chk(ctlo_pkg::IDX_PREP + 10'(j), rst_v[j], ok);
      rd_chk(10'h044, 32'h0000_0000, dec);
      axi_write(10'h03F, 8'h85, 1'b1, dec);
      for (int r = 0; r < 6; r++)
      begin
         lane_rate_sel <= 3'(r);
         @(posedge aclk);
         for (int j = 0; j < 4; j++)
            rd_chk(ctlo_pkg::IDX_PREP + 10'(j), {25'h0, auto_v[r][j]}, ok);
      end
      lane_rate_sel <= ctlo_pkg::RATE_800;
      for (int j = 0; j < 4; j++)
      begin
         // the value field ignores writes until override is already set
         axi_write(ctlo_pkg::IDX_PREP + 10'(j), 8'h15, 1'b1, ok);
         rd_chk(ctlo_pkg::IDX_PREP + 10'(j), {25'h0, auto_v[1][j]}, ok);
         axi_write(ctlo_pkg::IDX_PREP + 10'(j), 8'h95, 1'b1, ok);
         rd_chk(ctlo_pkg::IDX_PREP + 10'(j), {24'h0, 1'b1, auto_v[1][j]}, ok);
         axi_write(ctlo_pkg::IDX_PREP + 10'(j), {1'b1, ovr_v[j]}, 1'b1, ok);
         axi_write(ctlo_pkg::IDX_PREP + 10'(j), 8'h00, 1'b0, ok);
         rd_chk(ctlo_pkg::IDX_PREP + 10'(j), {24'h0, 1'b1, ovr_v[j]}, ok);
      end
      lane_rate_sel <= ctlo_pkg::RATE_400;
      for (int j = 0; j < 4; j++)
         rd_chk(ctlo_pkg::IDX_PREP + 10'(j), {24'h0, 1'b1, ovr_v[j]}, ok);
      lane_run(2, 4, 3, 5);
      for (int j = 0; j < 4; j++)
      begin
         axi_write(ctlo_pkg::IDX_PREP + 10'(j), 8'h00, 1'b1, ok);
         rd_chk(ctlo_pkg::IDX_PREP + 10'(j), {25'h0, auto_v[0][j]}, ok);
      end
      lane_run(3, 14, 7, 6);
      final_report();
   end
endmodule
